//--- dv/phy_core_model.sv
// event source standing in for the phy core
// assumes the bench raises a request one cycle ahead
`timescale 1ns/1ps
`default_nettype none
module phy_core_model (
  // clock
  input wire logic clk,
  // requests from the bench, status bit order
  input wire logic [6:0] fire,
  // event pulses
  output logic [6:0] evt
);
  // registered, so a request becomes one clean pulse
  always_ff @(posedge clk) begin
    evt <= fire;
  end
endmodule
`default_nettype wire

//--- dv/phy_tx_regs_properties.sv
// port assertions for the register slice
// assumes one clock and the one-cycle ack of the slave
`timescale 1ns/1ps
`default_nettype none
module phy_tx_regs_properties (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // core side
  input wire logic negotiation_done,
  input wire logic [2:0] current_operating_mode,
  input wire logic rx_error_counter_off,
  input wire logic remote_loopback_on,
  input wire logic dc_restore_on,
  input wire logic line_code_conversion_on,
  input wire logic transmit_isolate,
  input wire logic three_level_coding_bypass,
  input wire logic scrambler_bypass,
  input wire logic phy_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire ctl = take & (wb_adr_i == phy_regs_pkg::tx_control_off);
  wire wr_lo = ctl & wb_we_i & wb_sel_i[0];
  wire wr_hi = ctl & wb_we_i & wb_sel_i[1];
  wire rd = ctl & ~wb_we_i;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_ack_latency: assert property (take |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_reset_ctl: assert property ($past(sys_rst) |-> dc_restore_on && line_code_conversion_on && !transmit_isolate)
    else $error("control reset value wrong");
  a_irq_reset: assert property ($past(sys_rst) |-> !phy_irq)
    else $error("irq high out of reset");
  a_ctl_hi: assert property (wr_hi |=> rx_error_counter_off == $past(wb_dat_i[13])
    && remote_loopback_on == $past(wb_dat_i[9]) && dc_restore_on == $past(wb_dat_i[8]))
    else $error("upper control write lost");
  a_ctl_lo: assert property (wr_lo |=> line_code_conversion_on == $past(wb_dat_i[7])
    && transmit_isolate == $past(wb_dat_i[5]) && three_level_coding_bypass == $past(wb_dat_i[1])
    && scrambler_bypass == $past(wb_dat_i[0]))
    else $error("lower control write lost");
  a_mirror_mode: assert property (rd |=> wb_dat_o[12] == $past(negotiation_done)
    && wb_dat_o[4:2] == $past(current_operating_mode))
    else $error("status mirror or mode wrong");
  a_reserved_zero: assert property (rd |=> wb_dat_o[31:14] == '0 && wb_dat_o[11:10] == '0 && !wb_dat_o[6])
    else $error("reserved control bits not zero");
  cover property (wr_lo);
  cover property (rd);
  cover property ($rose(phy_irq));
endmodule
bind phy_tx_regs phy_tx_regs_properties chk_u (.*);
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the register slice
// assumes the core model pulses events one cycle after a request
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = '0, sys_rst = 1'b1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, negotiation_done = '0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, r;
  logic [2:0] current_operating_mode = '0;
  logic [6:0] fire = '0, evt;
  logic wb_ack_o, rx_error_counter_off, remote_loopback_on, dc_restore_on, line_code_conversion_on;
  logic transmit_isolate, three_level_coding_bypass, scrambler_bypass, phy_irq;
  logic [15:0] w;
  int n_mismatch = 0, cmp_count = 0;
  wire neg_done_evt = evt[6], remote_fault_evt = evt[5], link_fail_evt = evt[4], partner_ack_evt = evt[3];
  wire parallel_fault_evt = evt[2], page_received_evt = evt[1], rx_error_evt = evt[0];
  // control pins in the order 13, 9, 8, 7, 5, 1, 0 of the control word
  wire [6:0] ctl_pins = {rx_error_counter_off, remote_loopback_on, dc_restore_on, line_code_conversion_on,
                         transmit_isolate, three_level_coding_bypass, scrambler_bypass};
  phy_tx_regs dut_u (.*);
  phy_core_model core_u (.clk(clk), .fire(fire), .evt(evt));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the answer is taken at the edge that sees ack
  task automatic wbc(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hf};
    n = 0;
    do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("Error %0t: no ack from register slave", $time);
    end
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= '0;
    if (!we) chk(r, exp);
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk); fire <= 7'(7'h1 << k);
      @(posedge clk); fire <= '0;
    end
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] ctl_exp(input logic [15:0] d, input logic nd, input logic [2:0] m);
    return {16'h0, d & phy_regs_pkg::tx_control_wmask} | {19'h0, nd, 12'h0} | {27'h0, m, 2'h0};
  endfunction
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    $display("Error %0t: watchdog ran out", $time);
    end_sim;
  end
  initial begin
    void'($urandom(51038));
    repeat (8) @(posedge clk);
    sys_rst <= '0;
    wbc(1'b0, phy_regs_pkg::irq_enable_off, '0, '0);
    wbc(1'b0, phy_regs_pkg::tx_control_off, '0, 32'h180);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom());
      current_operating_mode <= 3'(i);
      negotiation_done <= w[15];
      wbc(1'b1, phy_regs_pkg::irq_enable_off, {16'h0, w}, '0);
      wbc(1'b0, phy_regs_pkg::irq_enable_off, '0, {25'h0, w[6:0]});
      wbc(1'b1, phy_regs_pkg::tx_control_off, {16'h0, w}, '0);
      wbc(1'b0, phy_regs_pkg::tx_control_off, '0, ctl_exp(w, w[15], 3'(i)));
      chk({25'h0, ctl_pins}, {25'h0, w[13], w[9:7], w[5], w[1:0]});
    end
    wbc(1'b1, 8'h10, '1, '0);
    wbc(1'b0, 8'h10, '0, '0);
    $display("register test done");
    wbc(1'b1, phy_regs_pkg::tx_control_off, 32'h180, '0);
    for (int k = 0; k < 7; k++) begin
      wbc(1'b1, phy_regs_pkg::irq_enable_off, {25'h0, 7'(7'h1 << k)}, '0);
      if (k == 0) begin
        pulse(0, 63);
        chk({31'h0, phy_irq}, '0);
        wbc(1'b0, phy_regs_pkg::error_count_off, '0, 32'h0000003f);
      end
      pulse(k, 1);
      chk({31'h0, phy_irq}, 32'h1);
      wbc(1'b0, phy_regs_pkg::status_off, '0, 32'h1 << k);
      wbc(1'b0, phy_regs_pkg::status_off, '0, '0);
      repeat (2) @(posedge clk);
      chk({31'h0, phy_irq}, '0);
    end
    wbc(1'b1, phy_regs_pkg::irq_enable_off, '0, '0);
    pulse(5, 1);
    chk({31'h0, phy_irq}, '0);
    wbc(1'b0, phy_regs_pkg::status_off, '0, 32'h20);
    wbc(1'b1, phy_regs_pkg::tx_control_off, 32'h2180, '0);
    pulse(0, 64);
    wbc(1'b0, phy_regs_pkg::status_off, '0, '0);
    $display("event test done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wbc(1'b0, phy_regs_pkg::tx_control_off, '0, ctl_exp(16'h0180, negotiation_done, current_operating_mode));
    chk({25'h0, ctl_pins}, 32'h00000018);
    wbc(1'b0, phy_regs_pkg::irq_enable_off, '0, '0);
    chk({31'h0, phy_irq}, '0);
    $display("second reset test done");
    end_sim;
  end
endmodule
`default_nettype wire

//--- hw/phy_event_if.sv
// bundle between the register top and the event latch module
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface phy_event_if;
  logic [6:0] events;
  logic [6:0] flags;
  logic clear;
  logic counter_off;
  logic rx_error;
  logic [6:0] error_count;
  modport top (output events, output clear, output counter_off, output rx_error, input flags, input error_count);
  modport latch (input events, input clear, input counter_off, input rx_error, output flags, output error_count);
endinterface
`default_nettype wire

//--- hw/phy_event_latch.sv
// latched event flags and receive error counter
// assumes event inputs are already synchronous one-cycle or level pulses
`timescale 1ns/1ps
`default_nettype none
module phy_event_latch (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to register top
  phy_event_if.latch ev
);
  logic [6:1] flags_q;
  logic full_q;
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic full_w;
  wire logic count_en = ev.rx_error && !ev.counter_off && !count_q[6];
  assign count_d = count_en ? count_q + 7'h01 : count_q;
  assign full_w = (count_d >= phy_regs_pkg::rx_error_full_count);
  // set wins over the clear-on-read so no event is lost
  genvar i;
  generate
    for (i = 1; i < 7; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          flags_q[i] <= 1'b0;
        end else if (ev.events[i]) begin
          flags_q[i] <= 1'b1;
        end else if (ev.clear) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      full_q <= 1'b0;
      count_q <= 7'h00;
    end else begin
      // counter saturates at full; reading the flag restarts the count unless an error is counted in that cycle
      count_q <= (ev.clear && !count_en) ? 7'h00 : count_d;
      if (full_w && count_en) begin
        full_q <= 1'b1;
      end else if (ev.clear) begin
        full_q <= 1'b0;
      end
    end
  end
  // bit 0 kept in its own register so each variable has one driving process
  assign ev.flags = {flags_q, full_q};
  assign ev.error_count = count_q;
endmodule
`default_nettype wire

//--- hw/phy_regs_pkg.sv
// constants for the transceiver interrupt enable / tx control register slice
// assumes a 32-bit classic wishbone slave with byte addresses
package phy_regs_pkg;
  localparam logic [7:0] status_off = 8'hd4;
  localparam logic [7:0] irq_enable_off = 8'hd8;
  localparam logic [7:0] tx_control_off = 8'hdc;
  localparam logic [7:0] error_count_off = 8'he0;
  localparam logic [6:0] status_mask = 7'h7f;
  localparam logic [6:0] irq_enable_mask = 7'h7f;
  localparam logic [6:0] irq_enable_reset = 7'h00;
  localparam logic [15:0] tx_control_wmask = 16'h23a3;
  localparam logic [15:0] tx_control_reset = 16'h0180;
  localparam int ctl_counter_off_bit = 13;
  localparam int ctl_neg_done_bit = 12;
  localparam int ctl_remote_loop_bit = 9;
  localparam int ctl_dc_restore_bit = 8;
  localparam int ctl_line_code_bit = 7;
  localparam int ctl_isolate_bit = 5;
  localparam int ctl_mode_lo_bit = 2;
  localparam int ctl_mlt3_bit = 1;
  localparam int ctl_scramble_bit = 0;
  localparam logic [6:0] rx_error_full_count = 7'h40;
  localparam logic [2:0] mode_negotiating = 3'h0;
  localparam logic [2:0] mode_10_half = 3'h1;
  localparam logic [2:0] mode_100_half = 3'h2;
  localparam logic [2:0] mode_10_full = 3'h5;
  localparam logic [2:0] mode_100_full = 3'h6;
  localparam logic [2:0] mode_isolated = 3'h7;
endpackage

//--- hw/phy_tx_regs.sv
// transceiver interrupt enable and 100base-tx control register slice
// assumes a classic wishbone master and synchronous status inputs from the phy core
//
// Notes on behaviour
// - receive error full flag sets at 64 counted errors, latches, clears on read
// - bit 6 enable gates negotiation complete interrupt, reset 0
// - bit 5 enable gates remote fault interrupt, reset 0
// - bit 4 enable gates link down interrupt, reset 0
// - bit 3 enable gates partner acknowledge interrupt
// - bit 2 enable gates parallel detection fault interrupt, reset 0
// - bit 1 enable gates page received interrupt, reset 0
// - bit 0 enable gates receive error full interrupt, reset 0
// - control bit 13 set stops the receive error counter
// - control bit 12 mirrors negotiation complete from basic status
// - control bit 9 enables remote loopback; software keeps mac loop mode 00
// - control bit 8 enables dc restoration, reset 1
// - control bit 7 enables nrz/nrzi conversion both ways, reset 1
// - control bit 5 isolates the transmitter, reset 0
// - bits 4..2 report operating mode codes, read only
// - control bit 1 bypasses mlt3 encoder and decoder
// - control bit 0 disables scrambler and descrambler
// - status flags latch at enable positions and clear on read
`timescale 1ns/1ps
`default_nettype none
module phy_tx_regs (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // events from the phy core, one-cycle pulses
  input wire logic neg_done_evt,
  input wire logic remote_fault_evt,
  input wire logic link_fail_evt,
  input wire logic partner_ack_evt,
  input wire logic parallel_fault_evt,
  input wire logic page_received_evt,
  input wire logic rx_error_evt,
  // phy core state
  input wire logic negotiation_done,
  input wire logic [2:0] current_operating_mode,
  // controls to the phy datapath
  output logic rx_error_counter_off,
  output logic remote_loopback_on,
  output logic dc_restore_on,
  output logic line_code_conversion_on,
  output logic transmit_isolate,
  output logic three_level_coding_bypass,
  output logic scrambler_bypass,
  // interrupt request
  output logic phy_irq
);
  phy_event_if ev ();

  logic [6:0] irq_en_q;
  logic [15:0] ctl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic irq_q;

  // decode
  wire logic req_w = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wr_w = req_w && wb_we_i;
  wire logic rd_w = req_w && !wb_we_i;
  wire logic sel_status = (wb_adr_i == phy_regs_pkg::status_off);
  wire logic sel_irq_en = (wb_adr_i == phy_regs_pkg::irq_enable_off);
  wire logic sel_ctl = (wb_adr_i == phy_regs_pkg::tx_control_off);
  wire logic sel_count = (wb_adr_i == phy_regs_pkg::error_count_off);
  wire logic [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [15:0] ctl_wmask = lane_mask & phy_regs_pkg::tx_control_wmask;

  // read-only fields merged into the control word
  logic [15:0] ctl_view;
  always_comb begin
    ctl_view = ctl_q & phy_regs_pkg::tx_control_wmask;
    ctl_view[phy_regs_pkg::ctl_neg_done_bit] = negotiation_done;
    ctl_view[phy_regs_pkg::ctl_mode_lo_bit +: 3] = current_operating_mode;
  end

  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h00000000;
    if (sel_status) begin
      rdata_d[6:0] = ev.flags & phy_regs_pkg::status_mask;
    end else if (sel_irq_en) begin
      rdata_d[6:0] = irq_en_q;
    end else if (sel_ctl) begin
      rdata_d[15:0] = ctl_view;
    end else if (sel_count) begin
      rdata_d[6:0] = ev.error_count;
    end
  end

  // reading status clears the flags only when the low lane is selected
  assign ev.clear = rd_w && sel_status && wb_sel_i[0];
  assign ev.events = {neg_done_evt, remote_fault_evt, link_fail_evt, partner_ack_evt,
                      parallel_fault_evt, page_received_evt, 1'b0};
  assign ev.rx_error = rx_error_evt;
  assign ev.counter_off = ctl_q[phy_regs_pkg::ctl_counter_off_bit];

  phy_event_latch u_latch (
    .clk(clk),
    .sys_rst(sys_rst),
    .ev(ev)
  );

  // every access answers in one cycle; unmapped reads give zero, writes dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req_w;
      if (rd_w) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_en_q <= phy_regs_pkg::irq_enable_reset;
    end else if (wr_w && sel_irq_en && wb_sel_i[0]) begin
      irq_en_q <= wb_dat_i[6:0] & phy_regs_pkg::irq_enable_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_q <= phy_regs_pkg::tx_control_reset;
    end else if (wr_w && sel_ctl) begin
      ctl_q <= (ctl_q & ~ctl_wmask) | (wb_dat_i[15:0] & ctl_wmask);
    end
  end

  // registered so the request follows the flags by one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev.flags & irq_en_q);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign phy_irq = irq_q;
  assign rx_error_counter_off = ctl_q[phy_regs_pkg::ctl_counter_off_bit];
  assign remote_loopback_on = ctl_q[phy_regs_pkg::ctl_remote_loop_bit];
  assign dc_restore_on = ctl_q[phy_regs_pkg::ctl_dc_restore_bit];
  assign line_code_conversion_on = ctl_q[phy_regs_pkg::ctl_line_code_bit];
  assign transmit_isolate = ctl_q[phy_regs_pkg::ctl_isolate_bit];
  assign three_level_coding_bypass = ctl_q[phy_regs_pkg::ctl_mlt3_bit];
  assign scrambler_bypass = ctl_q[phy_regs_pkg::ctl_scramble_bit];
endmodule
`default_nettype wire
